// [design/tsc_channel.sv]
`timescale 1ns/10ps
module tsc_channel #(
    parameter bit CH_HAS_D = 1'b1 // 1: channel 0/3 kind
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Register bus
    input wire tsc_pkg::tsc_apb_req_t apb_req,
    output tsc_pkg::tsc_apb_rsp_t apb_rsp,
    // Channel 4 count source
    input wire logic ch4_count_pulse,
    input wire logic [2:0] prescaler_select,
    // Transfer controller
    input wire logic xfer_start,
    input wire logic disable_after_transfer,
    // Pins and request
    input wire logic ch3_capture_pin_d,
    output logic ch3_out_d,
    output logic capcmp_d_irq
);
    import tsc_pkg::*;

    // ------------------------------------------------------------------
    // State and derived terms
    // ------------------------------------------------------------------
    tsc_state_t st_r; // Registered state
    tsc_state_t st_nxt; // Next state
    logic pin_rise; // Filtered pin edges
    logic pin_fall;
    logic setup; // Setup phase seen
    logic acc; // Access completes this edge
    logic wr_stat; // Completing writes and reads
    logic rd_stat;
    logic wr_ctrl;
    logic wr_cnt;
    logic wr_grd;
    logic addr_hit; // Mapped address
    logic [7:0] stat_val; // Status as read
    logic [31:0] rd_mux; // Read data
    logic down; // Effective direction
    logic [15:0] cnt_step; // Counter after one tick
    logic ovf_ev; // Events this cycle
    logic unf_ev;
    logic cmp_ev;
    logic cap_ev;
    logic oc_mode; // D acts as output compare
    logic ic_mode; // D acts as input capture
    logic cap_pin; // Pin capture source fired
    logic cap_ch4; // Channel 4 capture source fired
    logic dtc_clr; // Transfer controller clear

    // ------------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------------
    tsc_pin_sync u_sync (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .pin_in(ch3_capture_pin_d),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    // Zero wait: answer prepared in setup, taken in access phase
    assign setup = apb_req.psel & ~apb_req.penable;
    assign acc = apb_req.psel & apb_req.penable & st_r.rsp.pready;
    assign wr_stat = acc & apb_req.pwrite &
                     (apb_req.paddr == TSC_OFS_STATUS);
    assign rd_stat = acc & ~apb_req.pwrite &
                     (apb_req.paddr == TSC_OFS_STATUS);
    assign wr_ctrl = acc & apb_req.pwrite &
                     (apb_req.paddr == TSC_OFS_CTRL);
    assign wr_cnt = acc & apb_req.pwrite &
                    (apb_req.paddr == TSC_OFS_COUNT);
    assign wr_grd = acc & apb_req.pwrite &
                    (apb_req.paddr == TSC_OFS_GRD);
    assign addr_hit = (apb_req.paddr == TSC_OFS_STATUS) ||
                      (apb_req.paddr == TSC_OFS_CTRL) ||
                      (apb_req.paddr == TSC_OFS_COUNT) ||
                      (apb_req.paddr == TSC_OFS_GRD);

    // Status image, reserved bits fixed
    always_comb begin
        stat_val = 8'h00;
        stat_val[TSC_B_RSV6] = 1'b1;
        stat_val[TSC_B_OVF] = st_r.ovf;
        // Bit 5 only lives where bit 3 does not
        stat_val[TSC_B_UNF] = CH_HAS_D ? 1'b0 : st_r.unf;
        stat_val[TSC_B_TGF] = CH_HAS_D ? st_r.tgf : 1'b0;
    end

    // Read multiplexer, unmapped reads zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (apb_req.paddr)
            TSC_OFS_STATUS: rd_mux[7:0] = stat_val;
            TSC_OFS_CTRL: rd_mux[7:0] = {st_r.phase, st_r.down, st_r.cen,
                                         st_r.bfb, st_r.io};
            TSC_OFS_COUNT: rd_mux[15:0] = st_r.cnt;
            TSC_OFS_GRD: rd_mux[15:0] = st_r.grd;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------------
    // Counter events
    // ------------------------------------------------------------------
    // Down counting exists only in phase mode of non-D channels
    assign down = ~CH_HAS_D & st_r.phase & st_r.down;
    assign cnt_step = down ? st_r.cnt - 16'h0001 : st_r.cnt + 16'h0001;
    // A software load replaces the tick, so it cannot wrap
    assign ovf_ev = st_r.cen & ~wr_cnt & ~down &
                    (st_r.cnt == TSC_CNT_MAX);
    assign unf_ev = st_r.cen & ~wr_cnt & down &
                    (st_r.cnt == TSC_CNT_MIN);

    // ------------------------------------------------------------------
    // Capture and compare selection
    // ------------------------------------------------------------------
    // Buffer mode turns both functions off
    assign oc_mode = CH_HAS_D & ~st_r.io[3] & ~st_r.bfb;
    assign ic_mode = CH_HAS_D & st_r.io[3] & ~st_r.bfb;
    assign cmp_ev = oc_mode & st_r.cen & (cnt_step == st_r.grd);
    // Pin source: both edges win over the edge bit
    assign cap_pin = ~st_r.io[2] & (st_r.io[1] ? (pin_rise | pin_fall) :
                     (st_r.io[0] ? pin_fall : pin_rise));
    // Channel 4 source, invalid on undivided clock
    assign cap_ch4 = st_r.io[2] & ch4_count_pulse &
                     (prescaler_select != TSC_PSC_UNDIV);
    assign cap_ev = ic_mode & (cap_pin | cap_ch4);
    assign dtc_clr = xfer_start & ~disable_after_transfer;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        // Answer pulses for one access phase
        st_nxt.rsp.pready = 1'b0;
        st_nxt.rsp.pslverr = 1'b0;
        if (setup) begin
            st_nxt.rsp.pready = 1'b1;
            st_nxt.rsp.pslverr = ~addr_hit;
            st_nxt.rsp.prdata = rd_mux;
        end
        // Counter: software write beats a tick
        if (wr_cnt) begin
            st_nxt.cnt = apb_req.pwdata[15:0];
        end else if (st_r.cen) begin
            st_nxt.cnt = cnt_step;
        end
        // Control register
        if (wr_ctrl) begin
            st_nxt.io = apb_req.pwdata[TSC_C_IO +: 4];
            st_nxt.bfb = apb_req.pwdata[TSC_C_BFB];
            st_nxt.cen = apb_req.pwdata[TSC_C_CEN];
            st_nxt.down = apb_req.pwdata[TSC_C_DOWN];
            st_nxt.phase = apb_req.pwdata[TSC_C_PHASE];
        end
        // Register D: capture beats a software write
        if (cap_ev) begin
            st_nxt.grd = st_r.cnt;
        end else if (wr_grd) begin
            st_nxt.grd = apb_req.pwdata[15:0];
        end
        // Output pin: new select loads the initial level
        if (wr_ctrl) begin
            if (!apb_req.pwdata[TSC_C_IO + 3] &&
                apb_req.pwdata[TSC_C_IO +: 2] != 2'b00) begin
                st_nxt.pin_out = apb_req.pwdata[TSC_C_IO + 2];
            end
        end else if (cmp_ev) begin
            case (st_r.io[1:0])
                2'b01: st_nxt.pin_out = 1'b0;
                2'b10: st_nxt.pin_out = 1'b1;
                2'b11: st_nxt.pin_out = ~st_r.pin_out;
                default: st_nxt.pin_out = st_r.pin_out; // Disabled
            endcase
        end
        // Arming: a one seen by a read permits the next zero write
        // Arm from the image handed out, not from a flag set since setup
        if (rd_stat) begin
            st_nxt.arm_unf = st_r.arm_unf | st_r.rsp.prdata[TSC_B_UNF];
            st_nxt.arm_ovf = st_r.arm_ovf | st_r.rsp.prdata[TSC_B_OVF];
            st_nxt.arm_tgf = st_r.arm_tgf | st_r.rsp.prdata[TSC_B_TGF];
        end
        if (wr_stat) begin
            st_nxt.arm_unf = 1'b0;
            st_nxt.arm_ovf = 1'b0;
            st_nxt.arm_tgf = 1'b0;
        end
        // Flags: writing one does nothing, a fresh event beats a clear
        if (wr_stat && !apb_req.pwdata[TSC_B_UNF] && st_r.arm_unf) begin
            st_nxt.unf = 1'b0;
        end
        if (wr_stat && !apb_req.pwdata[TSC_B_OVF] && st_r.arm_ovf) begin
            st_nxt.ovf = 1'b0;
        end
        if ((wr_stat && !apb_req.pwdata[TSC_B_TGF] && st_r.arm_tgf) ||
            dtc_clr) begin
            st_nxt.tgf = 1'b0;
        end
        if (unf_ev) begin
            st_nxt.unf = 1'b1;
        end
        if (ovf_ev) begin
            st_nxt.ovf = 1'b1;
        end
        if (cmp_ev || cap_ev) begin
            st_nxt.tgf = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            st_r <= '0;
            st_r.cnt <= TSC_CNT_RST;
            st_r.grd <= TSC_GRD_RST;
            st_r.io <= TSC_IO_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign apb_rsp = st_r.rsp;
    assign ch3_out_d = st_r.pin_out;
    assign capcmp_d_irq = st_r.tgf;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    toggle_flip_a: assert property (
        cmp_ev && st_r.io[1:0] == 2'b11 && !wr_ctrl
        |=> ch3_out_d != $past(ch3_out_d))
        else $error("toggle output did not invert");

    pin_cap_a: assert property (
        ic_mode && !st_r.io[2] && !st_r.io[1] &&
        (st_r.io[0] ? pin_fall : pin_rise)
        |=> st_r.grd == $past(st_r.cnt) && st_r.tgf)
        else $error("pin edge capture missed");

    both_edge_a: assert property (
        ic_mode && st_r.io[2:1] == 2'b01 && (pin_rise || pin_fall)
        |=> st_r.tgf && st_r.grd == $past(st_r.cnt))
        else $error("both edge capture missed");

    ch4_cap_a: assert property (
        ic_mode && st_r.io[2] && ch4_count_pulse &&
        prescaler_select != 3'h0
        |=> st_r.grd == $past(st_r.cnt))
        else $error("channel 4 capture missed");

    ch4_invalid_a: assert property (
        st_r.io[3:2] == 2'b11 && prescaler_select == 3'h0 && !wr_grd
        |=> $stable(st_r.grd))
        else $error("capture on undivided clock");

    buf_block_a: assert property (
        st_r.bfb |=> !$rose(st_r.tgf))
        else $error("flag set in buffer mode");

    rsv_bit6_a: assert property (
        apb_rsp.pready && apb_req.paddr == 8'h00 && !apb_req.pwrite
        |-> apb_rsp.prdata[6])
        else $error("bit 6 read as zero");

    ovf_set_a: assert property (
        st_r.cen && !down && st_r.cnt == 16'hFFFF
        |=> st_r.ovf && st_r.cnt == 16'h0000 || $past(wr_cnt))
        else $error("overflow not flagged");

    unf_rsv_a: assert property (
        CH_HAS_D |-> !st_r.unf && !stat_val[5])
        else $error("reserved bit 5 set");

    clr_armed_a: assert property (
        st_r.ovf && !st_r.arm_ovf && wr_stat |=> st_r.ovf)
        else $error("flag cleared without read");

    dtc_clear_a: assert property (
        dtc_clr && !cmp_ev && !cap_ev |=> !st_r.tgf)
        else $error("transfer start left flag set");

    // Flag setting, reserved bits and write rules
    unf_set_a: assert property (
        unf_ev
        |=> st_r.unf && st_r.cnt == TSC_CNT_MAX)
        else $error("underflow not flagged");

    cmp_flag_a: assert property (
        cmp_ev && !wr_grd && !wr_cnt
        |=> st_r.tgf && st_r.cnt == st_r.grd)
        else $error("compare match not flagged");

    tgf_rsv_a: assert property (
        !CH_HAS_D |-> !st_r.tgf && !stat_val[TSC_B_TGF])
        else $error("reserved bit 3 set");

    unf_armed_a: assert property (
        st_r.unf && !st_r.arm_unf && wr_stat |=> st_r.unf)
        else $error("underflow cleared without read");

    write_one_a: assert property (
        wr_stat && apb_req.pwdata[TSC_B_OVF] && st_r.ovf |=> st_r.ovf)
        else $error("writing one cleared a flag");

    // A capture needs an edge of the selected source
    pin_src_a: assert property (
        ic_mode && !st_r.io[2] && !pin_rise && !pin_fall && !wr_grd
        |=> $stable(st_r.grd))
        else $error("capture without pin edge");

    // With register D present the counter never runs down
    up_only_a: assert property (
        CH_HAS_D && st_r.cen && !wr_cnt
        |=> st_r.cnt == 16'($past(st_r.cnt) + 16'h0001))
        else $error("counter ran down");

    cmp_cov_c: cover property (cmp_ev && st_r.io[1:0] == 2'b11);
    unf_cov_c: cover property (unf_ev);
    dtc_cov_c: cover property (dtc_clr && st_r.tgf);
    cap_cov_c: cover property (cap_ev ##1 rd_stat);
    clr_cov_c: cover property (rd_stat && st_r.ovf ##[1:8] wr_stat);

endmodule

// [design/tsc_pkg.sv]
package tsc_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses, one word each)
    // ------------------------------------------------------------------
    localparam logic [7:0] TSC_OFS_STATUS = 8'h00; // Status flags
    localparam logic [7:0] TSC_OFS_CTRL = 8'h04;   // Mode and select
    localparam logic [7:0] TSC_OFS_COUNT = 8'h08;  // Counter value
    localparam logic [7:0] TSC_OFS_GRD = 8'h0C;    // Compare register D

    // ------------------------------------------------------------------
    // Status field positions
    // ------------------------------------------------------------------
    localparam int TSC_B_RSV6 = 6; // Reserved, reads one
    localparam int TSC_B_UNF = 5;  // Underflow flag
    localparam int TSC_B_OVF = 4;  // Overflow flag
    localparam int TSC_B_TGF = 3;  // Capture/compare D flag

    // ------------------------------------------------------------------
    // Control field positions
    // ------------------------------------------------------------------
    localparam int TSC_C_IO = 0;    // io select d, bits 3..0
    localparam int TSC_C_BFB = 4;   // Buffer mode d
    localparam int TSC_C_CEN = 5;   // Counter enable
    localparam int TSC_C_DOWN = 6;  // Count downward
    localparam int TSC_C_PHASE = 7; // Phase counting mode

    // ------------------------------------------------------------------
    // Reset values and counter limits
    // ------------------------------------------------------------------
    localparam logic [15:0] TSC_CNT_RST = 16'h0000;
    localparam logic [15:0] TSC_GRD_RST = 16'hFFFF;
    localparam logic [15:0] TSC_CNT_MAX = 16'hFFFF;
    localparam logic [15:0] TSC_CNT_MIN = 16'h0000;
    localparam logic [3:0] TSC_IO_RST = 4'h0;
    localparam logic [2:0] TSC_PSC_UNDIV = 3'h0; // Undivided clock

    // ------------------------------------------------------------------
    // Bus carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } tsc_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } tsc_apb_rsp_t;

    // ------------------------------------------------------------------
    // Whole state of the channel except the pin synchroniser
    // ------------------------------------------------------------------
    typedef struct packed {
        tsc_apb_rsp_t rsp;
        logic [15:0] cnt;
        logic [15:0] grd;
        logic [3:0] io;
        logic bfb;
        logic cen;
        logic down;
        logic phase;
        logic unf;
        logic ovf;
        logic tgf;
        logic arm_unf;
        logic arm_ovf;
        logic arm_tgf;
        logic pin_out;
    } tsc_state_t;

endpackage

// [design/tsc_pin_sync.sv]
`timescale 1ns/10ps
module tsc_pin_sync (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Asynchronous pin
    input wire logic pin_in,
    // Filtered edges, one cycle each
    output logic rise,
    output logic fall
);

    // ------------------------------------------------------------------
    // Three stage chain, level accepted when stages two and three agree
    // ------------------------------------------------------------------
    logic s1_r; // Only stage two reads this
    logic s2_r;
    logic s3_r;
    logic lvl_r; // Accepted level

    // Chain and edge pulses
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            lvl_r <= 1'b0;
            rise <= 1'b0;
            fall <= 1'b0;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            rise <= 1'b0;
            fall <= 1'b0;
            // A change counts only once it is stable over two stages
            if (s2_r == s3_r && s3_r != lvl_r) begin
                lvl_r <= s3_r;
                rise <= s3_r;
                fall <= ~s3_r;
            end
        end
    end

endmodule

// [sim/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
    import tsc_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk_sys = 1'b0; // 125 MHz system clock
    logic rst_b = 1'b0; // Synchronous reset, active low
    tsc_apb_req_t req; // Bus request driven here
    tsc_apb_rsp_t rsp; // Bus answer
    tsc_apb_req_t req_d; // Request seen by each channel kind
    tsc_apb_req_t req_u;
    tsc_apb_rsp_t rsp_d; // Answer of each channel kind
    tsc_apb_rsp_t rsp_u;
    logic sel_u = 1'b0; // Bus goes to the underflow kind
    logic irq_u; // Flag request of the underflow kind
    logic ch4_pulse = 1'b0; // Channel 4 count pulse
    logic [2:0] psc = 3'h1; // Channel 4 prescaler field
    logic xfer = 1'b0; // Transfer start pulse
    logic dat = 1'b0; // Disable-after-transfer level
    logic pin = 1'b0; // Capture pin level
    logic pin_out; // Compare output pin
    logic irq; // Flag request
    logic [32:0] expq[$]; // Notes of expected read answers
    int n_fail = 0;
    int checked = 0;
    logic [31:0] seed = 32'hACD13E6A; // Fixed seed
    logic [15:0] v; // Random counter value
    logic [7:0] ctab[5] = '{8'h05, 8'h03, 8'h17, 8'h07, 8'h02};
    logic ptab[5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
    logic ftab[5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
    logic [1:0] etab[4] = '{2'b10, 2'b01, 2'b11, 2'b11};

    always #4 clk_sys = ~clk_sys;

    // Only the selected channel kind sees the request
    assign req_d = sel_u ? tsc_apb_req_t'('0) : req;
    assign req_u = sel_u ? req : tsc_apb_req_t'('0);
    assign rsp = sel_u ? rsp_u : rsp_d;

    tsc_channel #(.CH_HAS_D(1'b1)) tsc_channel_inst (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .apb_req(req_d),
        .apb_rsp(rsp_d),
        .ch4_count_pulse(ch4_pulse),
        .prescaler_select(psc),
        .xfer_start(xfer),
        .disable_after_transfer(dat),
        .ch3_capture_pin_d(pin),
        .ch3_out_d(pin_out),
        .capcmp_d_irq(irq)
    );

    // Channel kind without register D, for the underflow flag
    if (1) begin : g_unf
        tsc_channel #(.CH_HAS_D(1'b0)) tsc_channel_inst (
            .clk_sys(clk_sys),
            .rst_b(rst_b),
            .apb_req(req_u),
            .apb_rsp(rsp_u),
            .ch4_count_pulse(ch4_pulse),
            .prescaler_select(psc),
            .xfer_start(xfer),
            .disable_after_transfer(dat),
            .ch3_capture_pin_d(pin),
            .ch3_out_d(),
            .capcmp_d_irq(irq_u)
        );
    end

    // ------------------------------------------------------------
    // Comparison and closing
    // ------------------------------------------------------------
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time,
                     seen, exp);
        end
    endtask

    task automatic results();
        $display("compares %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Bus master
    // ------------------------------------------------------------
    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, input logic [32:0] e);
        int n;
        n = 0;
        if (!wr) begin
            expq.push_back(e);
        end
        @(posedge clk_sys);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a,
                 pwdata: d};
        @(posedge clk_sys);
        req.penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_fail++;
        end
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d);
        apb(1'b0, a, 32'h0, {1'b0, d});
    endtask

    // Read answers taken at the completing edge, oldest note first
    always @(posedge clk_sys) begin
        if (req.psel && req.penable && rsp.pready === 1'b1
            && !req.pwrite) begin
            check({rsp.pslverr, rsp.prdata},
                  (expq.size() != 0) ? expq.pop_front() : 33'hX);
        end
    end

    // Watchdog: whole run is well under two thousand cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        results();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        req = '0;
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        // Reset values, reserved bits, unmapped place
        rd(TSC_OFS_STATUS, 32'h40);
        rd(TSC_OFS_GRD, 32'hFFFF);
        wr(TSC_OFS_STATUS, 32'hFF);
        rd(TSC_OFS_STATUS, 32'h40);
        apb(1'b0, 8'h10, 32'h0, {1'b1, 32'h0});
        // Wrap upward; the pass through FFFF also matches D
        wr(TSC_OFS_COUNT, 32'hFFFC);
        wr(TSC_OFS_CTRL, 32'h20);
        repeat (8) @(posedge clk_sys);
        wr(TSC_OFS_CTRL, 32'h0);
        wr(TSC_OFS_STATUS, 32'h0);
        rd(TSC_OFS_STATUS, 32'h58);
        wr(TSC_OFS_STATUS, 32'h18);
        rd(TSC_OFS_STATUS, 32'h58);
        wr(TSC_OFS_STATUS, 32'h0);
        rd(TSC_OFS_STATUS, 32'h40);
        // Compare modes; buffer mode entry must stay silent
        for (int i = 0; i < 5; i++) begin
            v = 16'($random(seed)) & 16'h7FFF | 16'h0100;
            wr(TSC_OFS_CTRL, {24'h0, ctab[i]});
            @(negedge clk_sys);
            check({32'h0, pin_out}, {32'h0, ctab[i][2]});
            wr(TSC_OFS_GRD, {16'h0, v});
            wr(TSC_OFS_COUNT, {16'h0, v - 16'h6});
            wr(TSC_OFS_CTRL, {24'h0, ctab[i] | 8'h20});
            repeat (12) @(posedge clk_sys);
            wr(TSC_OFS_CTRL, 32'h0);
            @(negedge clk_sys);
            check({32'h0, pin_out}, {32'h0, ptab[i]});
            rd(TSC_OFS_STATUS, {25'h0, 1'b1, 2'b0, ftab[i], 3'h0});
            wr(TSC_OFS_STATUS, 32'h0);
        end
        // Pin capture: rising, falling, both edges twice
        for (int m = 0; m < 4; m++) begin
            v = 16'($random(seed)) & 16'h7FFF;
            wr(TSC_OFS_GRD, 32'hFFFF);
            wr(TSC_OFS_CTRL, 32'h08 + m);
            wr(TSC_OFS_COUNT, {16'h0, v});
            for (int k = 1; k >= 0; k--) begin
                pin <= ~pin;
                repeat (8) @(posedge clk_sys);
                rd(TSC_OFS_STATUS, etab[m][k] ? 32'h48 : 32'h40);
                rd(TSC_OFS_GRD, etab[m][k] ? {16'h0, v} : 32'hFFFF);
                wr(TSC_OFS_STATUS, 32'h0);
                wr(TSC_OFS_GRD, 32'hFFFF);
            end
        end
        // Channel 4 counts: undivided clock first, then divided
        v = 16'($random(seed)) & 16'h7FFF;
        wr(TSC_OFS_CTRL, 32'h0C);
        wr(TSC_OFS_COUNT, {16'h0, v});
        for (int p = 0; p < 2; p++) begin
            psc <= p[0] ? 3'h5 : 3'h0;
            @(posedge clk_sys);
            ch4_pulse <= 1'b1;
            @(posedge clk_sys);
            ch4_pulse <= 1'b0;
            repeat (3) @(posedge clk_sys);
            rd(TSC_OFS_STATUS, p[0] ? 32'h48 : 32'h40);
            rd(TSC_OFS_GRD, p[0] ? {16'h0, v} : 32'hFFFF);
        end
        check({32'h0, irq}, 33'h1);
        // Transfer start: kept when disabled after transfer, else cleared
        for (int t = 0; t < 2; t++) begin
            dat <= ~t[0];
            xfer <= 1'b1;
            @(posedge clk_sys);
            xfer <= 1'b0;
            repeat (2) @(posedge clk_sys);
            check({32'h0, irq}, {32'h0, ~t[0]});
        end
        rd(TSC_OFS_STATUS, 32'h40);
        // Underflow kind: down bit alone counts up, phase mode wraps down
        sel_u <= 1'b1;
        for (int q = 0; q < 2; q++) begin
            wr(TSC_OFS_COUNT, 32'h3);
            wr(TSC_OFS_CTRL, q ? 32'hE0 : 32'h60);
            repeat (8) @(posedge clk_sys);
            wr(TSC_OFS_CTRL, 32'h0);
            rd(TSC_OFS_STATUS, q ? 32'h60 : 32'h40);
        end
        wr(TSC_OFS_STATUS, 32'h0);
        rd(TSC_OFS_STATUS, 32'h40);
        check({32'h0, irq_u}, 33'h0);
        results();
    end
endmodule
